// File: rtl/synth_test_defs.vh
// Purpose: shared offsets, fields, reset values and counts for the synthesizer test block
// Assumes: included by bare name from every design file except the divider counter and the ext_source model
// Notes: byte addresses of a 32-bit apb register window
`ifndef SYNTH_TEST_DEFS_VH
`define SYNTH_TEST_DEFS_VH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_MAIN_CP 8'h04
`define OFS_MAIN_REF_DIV 8'h08
`define OFS_MAIN_FB_DIV 8'h0c
`define OFS_MAIN_FRAC_NUM 8'h10
`define OFS_MAIN_FRAC_DEN 8'h14
`define OFS_AUX_REF_DIV 8'h18
`define OFS_AUX_FB_DIV 8'h1c
`define OFS_STATUS 8'h20

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_SEL_LSB 0
`define CTRL_SEL_MSB 3
`define CTRL_REF_BUF_ON 4
`define CTRL_MAIN_PD 5
`define CTRL_AUX_PD 6
`define CTRL_MAIN_CP_TRI 7
`define CTRL_AUX_CP_TRI 8
`define CTRL_MAIN_CP_POL 9
`define CTRL_AUX_CP_POL 10
`define CTRL_WIDTH 11
`define CTRL_RESET 11'h060

// ----------------------------------------------------------------
// main charge pump register fields
// ----------------------------------------------------------------
`define CP_STEADY_LSB 0
`define CP_STEADY_MSB 3
`define CP_BOOST_LSB 4
`define CP_BOOST_MSB 7
`define CP_BOOST_CNT_LSB 8
`define CP_BOOST_CNT_MSB 23
`define CP_RESET 24'h000010

// ----------------------------------------------------------------
// selector codes and divider reset values
// ----------------------------------------------------------------
`define SEL_AUX_REF 4'hc
`define SEL_AUX_FB 4'hd
`define SEL_MAIN_REF 4'he
`define SEL_MAIN_FB 4'hf
`define MAIN_REF_RESET 16'h0032
`define AUX_REF_RESET 16'h0032
`define MAIN_FB_RESET 16'h01f6
`define AUX_FB_RESET 16'h0216
`define FRAC_NUM_RESET 22'h1ffffe
`define FRAC_DEN_RESET 22'h3ffffd

`endif

// File: rtl/div_counter.v
// Purpose: programmable divide-by-n counter, one output pulse per n input events
// Assumes: tick is a one-cycle pulse on pclk
// Notes: a value of zero divides by one
`timescale 1ns/1ps
module div_counter #(
    parameter WIDTH = 16
) (
    input wire pclk,
    input wire presetn,
    input wire enable,
    input wire tick,
    input wire [WIDTH-1:0] div_value,
    output reg div_pulse
);

    reg [WIDTH-1:0] count_reg;
    wire [WIDTH-1:0] count_inc;
    wire wrap;

    assign count_inc = count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    // compare as >= so a smaller value written mid-count cannot strand the counter
    assign wrap = (count_inc >= div_value);

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_reg <= {WIDTH{1'b0}};
            div_pulse <= 1'b0;
        end
        else if (!enable)
        begin
            count_reg <= {WIDTH{1'b0}};
            div_pulse <= 1'b0;
        end
        else if (tick)
        begin
            count_reg <= wrap ? {WIDTH{1'b0}} : count_inc;
            div_pulse <= wrap;
        end
        else
        begin
            div_pulse <= 1'b0;
        end
    end

endmodule // div_counter

// File: rtl/synth_test_mux.v
// Purpose: divider observation mux, reference buffer and charge pump control of a dual synthesizer
// Assumes: pins are far slower than pclk; apb slave with zero wait states
// Notes: pins are oversampled on pclk, so edges are seen three to four cycles late
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "synth_test_defs.vh"
module synth_test_mux #(
    parameter DIV_WIDTH = 16,
    parameter FRAC_WIDTH = 22
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    input wire ref_input,
    input wire main_hf_input,
    input wire aux_hf_input,
    input wire ref_buffer_force_pin,
    output reg test_lock_pin,
    output reg buffered_ref_output,
    output reg main_section_on,
    output reg aux_section_on,
    output reg main_cp_up,
    output reg main_cp_down,
    output reg main_cp_drive_en,
    output reg aux_cp_up,
    output reg aux_cp_down,
    output reg aux_cp_drive_en,
    output reg [3:0] main_cp_gain
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // bit 0 ref, 1 main hf, 2 aux hf, 3 buffer force
    wire [3:0] pin_raw;
    reg [3:0] pin_s1_reg;
    reg [3:0] pin_s2_reg;
    reg [3:0] pin_s3_reg;
    reg [3:0] pin_lvl_reg;
    wire [3:0] pin_rise;
    assign pin_raw = {ref_buffer_force_pin, aux_hf_input, main_hf_input, ref_input};
    genvar gp;
    generate
        for (gp = 0; gp < 4; gp = gp + 1)
        begin : g_pin
            // a level counts only once the second and third stages agree
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pin_s1_reg[gp] <= 1'b0;
                    pin_s2_reg[gp] <= 1'b0;
                    pin_s3_reg[gp] <= 1'b0;
                    pin_lvl_reg[gp] <= 1'b0;
                end
                else
                begin
                    pin_s1_reg[gp] <= pin_raw[gp];
                    pin_s2_reg[gp] <= pin_s1_reg[gp];
                    pin_s3_reg[gp] <= pin_s2_reg[gp];
                    if (pin_s2_reg[gp] == pin_s3_reg[gp])
                        pin_lvl_reg[gp] <= pin_s3_reg[gp];
                end
            end
            assign pin_rise[gp] = (pin_s2_reg[gp] == pin_s3_reg[gp]) & pin_s3_reg[gp]
                & ~pin_lvl_reg[gp];
        end
    endgenerate

    // ----------------------------------------------------------------
    // apb registers
    // ----------------------------------------------------------------
    reg [`CTRL_WIDTH-1:0] ctrl_reg;
    reg [23:0] main_cp_reg;
    reg [DIV_WIDTH-1:0] main_ref_div_reg;
    reg [DIV_WIDTH-1:0] main_fb_div_reg;
    reg [FRAC_WIDTH-1:0] frac_num_reg;
    reg [FRAC_WIDTH-1:0] frac_den_reg;
    reg [DIV_WIDTH-1:0] aux_ref_div_reg;
    reg [DIV_WIDTH-1:0] aux_fb_div_reg;
    wire wr_en;
    wire rd_setup;
    reg addr_ok;
    reg [31:0] rd_data;
    wire [31:0] status_word;
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    // loaded in setup so read data stands through the access phase
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pslverr = psel & penable & ~addr_ok;
    always @*
    begin
        addr_ok = 1'b1;
        rd_data = 32'h0000_0000;
        case (paddr)
            `OFS_CTRL: rd_data[`CTRL_WIDTH-1:0] = ctrl_reg;
            `OFS_MAIN_CP: rd_data[23:0] = main_cp_reg;
            `OFS_MAIN_REF_DIV: rd_data[DIV_WIDTH-1:0] = main_ref_div_reg;
            `OFS_MAIN_FB_DIV: rd_data[DIV_WIDTH-1:0] = main_fb_div_reg;
            `OFS_MAIN_FRAC_NUM: rd_data[FRAC_WIDTH-1:0] = frac_num_reg;
            `OFS_MAIN_FRAC_DEN: rd_data[FRAC_WIDTH-1:0] = frac_den_reg;
            `OFS_AUX_REF_DIV: rd_data[DIV_WIDTH-1:0] = aux_ref_div_reg;
            `OFS_AUX_FB_DIV: rd_data[DIV_WIDTH-1:0] = aux_fb_div_reg;
            `OFS_STATUS: rd_data = status_word;
            default: addr_ok = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= `CTRL_RESET;
            main_cp_reg <= `CP_RESET;
            main_ref_div_reg <= `MAIN_REF_RESET;
            main_fb_div_reg <= `MAIN_FB_RESET;
            frac_num_reg <= `FRAC_NUM_RESET;
            frac_den_reg <= `FRAC_DEN_RESET;
            aux_ref_div_reg <= `AUX_REF_RESET;
            aux_fb_div_reg <= `AUX_FB_RESET;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            if (rd_setup)
                prdata <= rd_data;
            if (wr_en)
            begin
                case (paddr)
                    `OFS_CTRL: ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
                    `OFS_MAIN_CP: main_cp_reg <= pwdata[23:0];
                    `OFS_MAIN_REF_DIV: main_ref_div_reg <= pwdata[DIV_WIDTH-1:0];
                    `OFS_MAIN_FB_DIV: main_fb_div_reg <= pwdata[DIV_WIDTH-1:0];
                    `OFS_MAIN_FRAC_NUM: frac_num_reg <= pwdata[FRAC_WIDTH-1:0];
                    `OFS_MAIN_FRAC_DEN: frac_den_reg <= pwdata[FRAC_WIDTH-1:0];
                    `OFS_AUX_REF_DIV: aux_ref_div_reg <= pwdata[DIV_WIDTH-1:0];
                    `OFS_AUX_FB_DIV: aux_fb_div_reg <= pwdata[DIV_WIDTH-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // power control
    // ----------------------------------------------------------------
    wire main_on;
    wire aux_on;
    assign main_on = ~ctrl_reg[`CTRL_MAIN_PD];
    assign aux_on = ~ctrl_reg[`CTRL_AUX_PD];
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            main_section_on <= 1'b0;
            aux_section_on <= 1'b0;
        end
        else
        begin
            main_section_on <= main_on;
            aux_section_on <= aux_on;
        end
    end

    // ----------------------------------------------------------------
    // reference and feedback dividers
    // ----------------------------------------------------------------
    wire main_ref_pulse;
    wire main_fb_pulse;
    wire aux_ref_pulse;
    wire aux_fb_pulse;
    reg [FRAC_WIDTH-1:0] frac_acc_reg;
    reg frac_carry_reg;
    wire [FRAC_WIDTH:0] frac_sum;
    wire [DIV_WIDTH-1:0] main_fb_eff;
    wire frac_wrap;
    div_counter #(.WIDTH(DIV_WIDTH)) u_main_ref (
        .pclk(pclk),
        .presetn(presetn),
        .enable(main_on),
        .tick(pin_rise[0]),
        .div_value(main_ref_div_reg),
        .div_pulse(main_ref_pulse)
    );
    div_counter #(.WIDTH(DIV_WIDTH)) u_aux_ref (
        .pclk(pclk),
        .presetn(presetn),
        .enable(aux_on),
        .tick(pin_rise[0]),
        .div_value(aux_ref_div_reg),
        .div_pulse(aux_ref_pulse)
    );
    // first-order fraction: one extra count whenever the accumulator overflows
    assign frac_sum = {1'b0, frac_acc_reg} + {1'b0, frac_num_reg};
    assign frac_wrap = (frac_sum >= {1'b0, frac_den_reg});
    assign main_fb_eff = main_fb_div_reg + {{(DIV_WIDTH-1){1'b0}}, frac_carry_reg};
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frac_acc_reg <= {FRAC_WIDTH{1'b0}};
            frac_carry_reg <= 1'b0;
        end
        else if (!main_on)
        begin
            frac_acc_reg <= {FRAC_WIDTH{1'b0}};
            frac_carry_reg <= 1'b0;
        end
        else if (main_fb_pulse)
        begin
            frac_acc_reg <= frac_wrap ? frac_sum[FRAC_WIDTH-1:0] - frac_den_reg
                : frac_sum[FRAC_WIDTH-1:0];
            frac_carry_reg <= frac_wrap;
        end
    end
    div_counter #(.WIDTH(DIV_WIDTH)) u_main_fb (
        .pclk(pclk),
        .presetn(presetn),
        .enable(main_on),
        .tick(pin_rise[1]),
        .div_value(main_fb_eff),
        .div_pulse(main_fb_pulse)
    );

    div_counter #(.WIDTH(DIV_WIDTH)) u_aux_fb (
        .pclk(pclk),
        .presetn(presetn),
        .enable(aux_on),
        .tick(pin_rise[2]),
        .div_value(aux_fb_div_reg),
        .div_pulse(aux_fb_pulse)
    );

    // ----------------------------------------------------------------
    // test output selector and toggle stage
    // ----------------------------------------------------------------
    reg sel_pulse;
    wire [3:0] sel;
    assign sel = ctrl_reg[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
    always @*
    begin
        case (sel)
            `SEL_MAIN_REF: sel_pulse = main_ref_pulse;
            `SEL_MAIN_FB: sel_pulse = main_fb_pulse;
            `SEL_AUX_FB: sel_pulse = aux_fb_pulse;
            `SEL_AUX_REF: sel_pulse = aux_ref_pulse;
            default: sel_pulse = 1'b0;
        endcase
    end

    // the toggle gives a clean 50% square that a counter reads easily
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            test_lock_pin <= 1'b0;
        else if (sel < `SEL_AUX_REF)
            test_lock_pin <= 1'b0;
        else if (sel_pulse)
            test_lock_pin <= ~test_lock_pin;
    end

    // ----------------------------------------------------------------
    // reference buffer
    // ----------------------------------------------------------------
    wire buf_active;
    assign buf_active = ctrl_reg[`CTRL_REF_BUF_ON] | pin_lvl_reg[3];
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            buffered_ref_output <= 1'b0;
        else
            buffered_ref_output <= buf_active & pin_lvl_reg[0];
    end

    // ----------------------------------------------------------------
    // lock acquisition boost of the main pump
    // ----------------------------------------------------------------
    reg [15:0] boost_cnt_reg;
    wire boost_on;
    assign boost_on = (boost_cnt_reg != 16'h0000);
    // counted in comparison cycles, restarted by every write of the main feedback divider
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            boost_cnt_reg <= 16'h0000;
        else if (wr_en && paddr == `OFS_MAIN_FB_DIV)
            boost_cnt_reg <= main_cp_reg[`CP_BOOST_CNT_MSB:`CP_BOOST_CNT_LSB];
        else if (boost_on && main_ref_pulse)
            boost_cnt_reg <= boost_cnt_reg - 16'h0001;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            main_cp_gain <= 4'h0;
        else
            main_cp_gain <= boost_on ? main_cp_reg[`CP_BOOST_MSB:`CP_BOOST_LSB]
                : main_cp_reg[`CP_STEADY_MSB:`CP_STEADY_LSB];
    end

    // ----------------------------------------------------------------
    // phase detectors and charge pumps
    // ----------------------------------------------------------------
    // index 0 main loop, 1 aux loop; the aux pump has no gain control
    wire [1:0] pd_ref;
    wire [1:0] pd_fb;
    wire [1:0] loop_on;
    wire [1:0] loop_tri;
    wire [1:0] loop_pol;
    reg [1:0] lead_reg;
    reg [1:0] lag_reg;
    wire [1:0] up_w;
    wire [1:0] dn_w;
    assign pd_ref = {aux_ref_pulse, main_ref_pulse};
    assign pd_fb = {aux_fb_pulse, main_fb_pulse};
    assign loop_on = {aux_on, main_on};
    assign loop_tri = {ctrl_reg[`CTRL_AUX_CP_TRI], ctrl_reg[`CTRL_MAIN_CP_TRI]};
    assign loop_pol = {ctrl_reg[`CTRL_AUX_CP_POL], ctrl_reg[`CTRL_MAIN_CP_POL]};
    genvar gl;
    generate
        for (gl = 0; gl < 2; gl = gl + 1)
        begin : g_loop
            // pulse width equals the time between reference and feedback edges
            always @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    lead_reg[gl] <= 1'b0;
                    lag_reg[gl] <= 1'b0;
                end
                else
                begin
                    lead_reg[gl] <= loop_on[gl] & (lead_reg[gl] | pd_ref[gl])
                        & ~(lag_reg[gl] | pd_fb[gl]);
                    lag_reg[gl] <= loop_on[gl] & (lag_reg[gl] | pd_fb[gl])
                        & ~(lead_reg[gl] | pd_ref[gl]);
                end
            end
            assign up_w[gl] = loop_pol[gl] ? lag_reg[gl] : lead_reg[gl];
            assign dn_w[gl] = loop_pol[gl] ? lead_reg[gl] : lag_reg[gl];
        end
    endgenerate
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            main_cp_up <= 1'b0;
            main_cp_down <= 1'b0;
            main_cp_drive_en <= 1'b0;
            aux_cp_up <= 1'b0;
            aux_cp_down <= 1'b0;
            aux_cp_drive_en <= 1'b0;
        end
        else
        begin
            main_cp_up <= up_w[0] & ~loop_tri[0];
            main_cp_down <= dn_w[0] & ~loop_tri[0];
            main_cp_drive_en <= (up_w[0] | dn_w[0]) & ~loop_tri[0];
            aux_cp_up <= up_w[1] & ~loop_tri[1];
            aux_cp_down <= dn_w[1] & ~loop_tri[1];
            aux_cp_drive_en <= (up_w[1] | dn_w[1]) & ~loop_tri[1];
        end
    end
    assign status_word = {24'h000000, boost_on, buf_active, main_cp_drive_en,
        aux_cp_drive_en, pin_lvl_reg[3], aux_section_on, main_section_on, test_lock_pin};
endmodule // synth_test_mux

// File: dv/ext_source.sv
// Purpose: free-running reference and vco sources for the synthesizer test block
// Assumes: half periods in pclk cycles, edges launched right after pclk rises
// Notes: oscillators run free, so there is no idle level to model
`timescale 1ns/1ps
module ext_source #(
    parameter REF_HALF = 8,
    parameter MAIN_HALF = 12,
    parameter AUX_HALF = 10
) (
    input wire pclk,
    output reg ref_input = 1'b0,
    output reg main_hf_input = 1'b0,
    output reg aux_hf_input = 1'b0
);
    // ----
    // sources
    // ----
    integer k = 0;
    always @(posedge pclk)
    begin
        k <= k + 1;
        if (k % REF_HALF == 0) ref_input <= ~ref_input;
        if (k % MAIN_HALF == 0) main_hf_input <= ~main_hf_input;
        if (k % AUX_HALF == 0) aux_hf_input <= ~aux_hf_input;
    end
endmodule // ext_source

// File: dv/synth_test_mux_monitor.sv
// Purpose: port-level checker for the synthesizer test block
// Assumes: ctrl and pump settings are tracked from apb writes at the ports
// Notes: settings are judged only 4 cycles after the last write, pins lag the sync
`timescale 1ns/1ps
`include "synth_test_defs.vh"
module synth_test_mux_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire ref_buffer_force_pin,
    input wire test_lock_pin,
    input wire buffered_ref_output,
    input wire main_section_on,
    input wire aux_section_on,
    input wire main_cp_up,
    input wire main_cp_down,
    input wire main_cp_drive_en,
    input wire aux_cp_drive_en,
    input wire [3:0] main_cp_gain
);
    // ----
    // shadow of written settings
    // ----
    reg [10:0] ctrl_reg;
    reg [23:0] cp_reg;
    reg [2:0] age_reg;
    reg [3:0] off_reg;
    wire wr = psel && penable && pwrite;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= `CTRL_RESET;
            cp_reg <= `CP_RESET;
            age_reg <= 3'h7;
            off_reg <= 4'h0;
        end
        else
        begin
            age_reg <= wr ? 3'h0 : age_reg + {2'h0, age_reg != 3'h7};
            off_reg <= (ctrl_reg[4] || ref_buffer_force_pin) ? 4'h0 : off_reg + {3'h0, !off_reg[3]};
            if (wr && paddr == `OFS_CTRL) ctrl_reg <= pwdata[10:0];
            if (wr && paddr == `OFS_MAIN_CP) cp_reg <= pwdata[23:0];
        end
    end
    // ----
    // assertions
    // ----
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_bad_rd; psel && penable && !pwrite && paddr > `OFS_STATUS; endsequence
    sequence s_main_off; !main_section_on [*3]; endsequence
    property p_bad_rd; s_bad_rd |-> pslverr && prdata == 32'h0; endproperty
    a_bad_rd: assert property (p_bad_rd) else $error("unmapped read not refused");
    property p_slverr; pslverr |-> psel && penable; endproperty
    a_slverr: assert property (p_slverr) else $error("error flag outside access");
    property p_sel_low; age_reg[2] && ctrl_reg[3:0] < 4'hc |-> !test_lock_pin; endproperty
    a_sel_low: assert property (p_sel_low) else $error("test pin active, no divider");
    property p_toggle; $changed(test_lock_pin) |=> $stable(test_lock_pin); endproperty
    a_toggle: assert property (p_toggle) else $error("test pin not halved");
    property p_buf_off; off_reg[3] |-> !buffered_ref_output; endproperty
    a_buf_off: assert property (p_buf_off) else $error("reference buffer not off");
    property p_tri;
        age_reg[2] |-> !(ctrl_reg[7] && main_cp_drive_en) && !(ctrl_reg[8] && aux_cp_drive_en);
    endproperty
    a_tri: assert property (p_tri) else $error("pump drives while tri-stated");
    property p_gain;
        age_reg[2] |-> main_cp_gain == cp_reg[3:0] || main_cp_gain == cp_reg[7:4];
    endproperty
    a_gain: assert property (p_gain) else $error("pump gain not programmed");
    property p_pd;
        age_reg[2] |-> main_section_on == !ctrl_reg[5] && aux_section_on == !ctrl_reg[6];
    endproperty
    a_pd: assert property (p_pd) else $error("section power mismatch");
    property p_pd_pump; s_main_off |-> !main_cp_drive_en && !main_cp_up && !main_cp_down; endproperty
    a_pd_pump: assert property (p_pd_pump) else $error("pump active while down");
endmodule // synth_test_mux_monitor

bind synth_test_mux synth_test_mux_monitor u_synth_test_mux_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .ref_buffer_force_pin(ref_buffer_force_pin), .test_lock_pin(test_lock_pin),
    .buffered_ref_output(buffered_ref_output), .main_section_on(main_section_on),
    .aux_section_on(aux_section_on), .main_cp_up(main_cp_up), .main_cp_down(main_cp_down),
    .main_cp_drive_en(main_cp_drive_en), .aux_cp_drive_en(aux_cp_drive_en),
    .main_cp_gain(main_cp_gain)
);

// File: dv/tb.sv
// Purpose: self-checking bench for the synthesizer test block
// Assumes: zero-wait apb slave, sources with periods of 16, 24 and 20 cycles
// Notes: pins are synced, so periods are exact but edges lag by a few cycles
`timescale 1ns/1ps
`include "synth_test_defs.vh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, ref_buffer_force_pin, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, rd;
    wire pready, pslverr, ref_input, main_hf_input, aux_hf_input, test_lock_pin;
    wire buffered_ref_output, main_section_on, aux_section_on, main_cp_up, main_cp_down;
    wire main_cp_drive_en, aux_cp_up, aux_cp_down, aux_cp_drive_en;
    wire [31:0] prdata;
    wire [3:0] main_cp_gain;
    int n_mismatch = 0, checked = 0, c, tog, drv, hi, per;
    logic [31:0] rv [9] = '{`CTRL_RESET, `CP_RESET, `MAIN_REF_RESET, `MAIN_FB_RESET,
        `FRAC_NUM_RESET, `FRAC_DEN_RESET, `AUX_REF_RESET, `AUX_FB_RESET, 32'h0};
    logic [7:0] da [4] = '{`OFS_AUX_REF_DIV, `OFS_AUX_FB_DIV, `OFS_MAIN_REF_DIV, `OFS_MAIN_FB_DIV};

    synth_test_mux u_synth_test_mux (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .ref_input(ref_input),
        .main_hf_input(main_hf_input), .aux_hf_input(aux_hf_input),
        .ref_buffer_force_pin(ref_buffer_force_pin), .test_lock_pin(test_lock_pin),
        .buffered_ref_output(buffered_ref_output), .main_section_on(main_section_on),
        .aux_section_on(aux_section_on), .main_cp_up(main_cp_up), .main_cp_down(main_cp_down),
        .main_cp_drive_en(main_cp_drive_en), .aux_cp_up(aux_cp_up), .aux_cp_down(aux_cp_down),
        .aux_cp_drive_en(aux_cp_drive_en), .main_cp_gain(main_cp_gain));
    ext_source u_ext_source (.pclk(pclk), .ref_input(ref_input),
        .main_hf_input(main_hf_input), .aux_hf_input(aux_hf_input));

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // ----
    // tasks
    // ----
    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", checked, n_mismatch);
            if (n_mismatch == 0 && checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            checked++;
            if (seen !== exp)
            begin
                n_mismatch++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task stuck;
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            test_done;
        end
    endtask
    // holds the request until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        begin
            @(posedge pclk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
            @(posedge pclk);
            penable <= 1'b1;
            t = 0;
            do
            begin
                @(posedge pclk);
                t++;
            end
            while (pready !== 1'b1 && t < 50);
            if (t >= 50) stuck;
            err = pslverr;
            rd = prdata;
            {psel, penable} <= 2'b00;
        end
    endtask
    task settle;
        repeat (8) @(negedge pclk);
    endtask
    task win(input int n);
        logic p;
        begin
            {tog, drv, hi} = 0;
            p = buffered_ref_output;
            repeat (n)
            begin
                @(negedge pclk);
                tog += (buffered_ref_output !== p);
                p = buffered_ref_output;
                drv += ((main_cp_drive_en | aux_cp_drive_en) === 1'b1);
                hi += (test_lock_pin === 1'b1);
            end
        end
    endtask
    // cycles from now to the next rising edge of the test pin
    task rise;
        logic p;
        begin
            c = 0;
            do
            begin
                p = test_lock_pin;
                @(negedge pclk);
                c++;
            end
            while (!(p === 1'b0 && test_lock_pin === 1'b1) && c < 3000);
            if (c >= 3000) stuck;
        end
    endtask
    initial
    begin
        repeat (60000) @(posedge pclk);
        stuck;
    end
    // ----
    // stimulus
    // ----
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, ref_buffer_force_pin} = '0;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check(rd, rv[i]);
            check(err, 1'b0);
        end
        apb(1'b1, `OFS_STATUS, 32'hffffffff);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        $display("test registers done");
        apb(1'b1, `OFS_CTRL, 32'h180);
        settle;
        check({main_section_on, aux_section_on}, 2'b11);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rd[2:1], 2'b11);
        apb(1'b1, `OFS_CTRL, 32'h1a0);
        settle;
        check({main_section_on, aux_section_on}, 2'b01);
        $display("test power done");
        // integer main division keeps the test pin period exact
        apb(1'b1, `OFS_MAIN_FRAC_NUM, 32'h0);
        for (int s = 12; s < 16; s++)
        begin
            per = s[0] ? (s[1] ? 24 : 20) : 16;
            apb(1'b1, da[s - 12], 32'd3);
            apb(1'b1, `OFS_CTRL, 32'(s) | 32'h180 | (s[1] ? 32'h40 : 32'h20));
            rise;
            rise;
            check(c, 6 * per);
            win(6 * per);
            check(hi, 3 * per);
        end
        apb(1'b1, `OFS_CTRL, 32'h180);
        settle;
        win(200);
        check(hi + tog, 0);
        $display("test dividers done");
        apb(1'b1, `OFS_CTRL, 32'h190);
        settle;
        win(160);
        check(tog, 20);
        apb(1'b1, `OFS_CTRL, 32'h180);
        ref_buffer_force_pin <= 1'b1;
        settle;
        win(160);
        check(tog, 20);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check({rd[6], rd[3]}, 2'b11);
        ref_buffer_force_pin <= 1'b0;
        $display("test buffer done");
        apb(1'b1, `OFS_CTRL, 32'h000);
        win(600);
        check(drv > 0, 1'b1);
        apb(1'b1, `OFS_CTRL, 32'h180);
        settle;
        win(600);
        check(drv, 0);
        $display("test pumps done");
        for (int s = 0; s < 16; s++)
        begin
            apb(1'b1, `OFS_MAIN_CP, 32'(s));
            settle;
            check(main_cp_gain, s[3:0]);
        end
        apb(1'b1, `OFS_CTRL, 32'h000);
        apb(1'b1, `OFS_MAIN_CP, 32'h00045a);
        apb(1'b1, `OFS_MAIN_FB_DIV, 32'd3);
        repeat (2) @(negedge pclk);
        check(main_cp_gain, 4'h5);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rd[7], 1'b1);
        repeat (600) @(negedge pclk);
        check(main_cp_gain, 4'ha);
        $display("test gain done");
        test_done;
    end
endmodule // tb
